// File: rtl/sadc_control.sv
`timescale 1ns/1ps
`include "sadc_consts.svh"
module sadc_control
    import sadc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire logic [15:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    // analog macro
    output logic [1:0] analogChannel,
    output logic sampleHold,
    output logic [7:0] compareCode,
    input wire logic comparatorHigh,
    // events
    output logic conversionEndIrq,
    output logic firstResultFlag
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // conversion length from time select code; illegal codes fall back to the longest
    function automatic logic [7:0] convLength(input logic [2:0] sel);
        unique case (sel)
            3'b001: convLength = `SADC_LEN_001;
            3'b010: convLength = `SADC_LEN_010;
            3'b100: convLength = `SADC_LEN_100;
            3'b101: convLength = `SADC_LEN_101;
            3'b110: convLength = `SADC_LEN_110;
            default: convLength = `SADC_LEN_000;
        endcase
    endfunction

    sadc_state_type state_r;
    logic [7:0] mode_r;
    logic [1:0] chan_r;
    logic [7:0] approx_r;
    logic [7:0] result_r;
    logic [7:0] cycle_r;
    logic [7:0] stepLen_r;
    logic [3:0] bitIdx_r;
    logic compSync1_r;
    logic compSync2_r;
    logic first_r;
    logic modeWr;
    logic chanWr;
    logic enable;
    logic [7:0] convLen;
    logic [7:0] sampleLen;
    logic stepDone;
    logic convDone;

    assign modeWr = regWrite && (regAddr == `SADC_MODE_ADDR);
    assign chanWr = regWrite && (regAddr == `SADC_CHAN_ADDR);
    assign enable = mode_r[`SADC_ENABLE_BIT];
    assign convLen = convLength(mode_r[`SADC_TSEL_HI:`SADC_TSEL_LO]);
    // each step takes length/12; sample takes the first four steps
    assign sampleLen = 8'(convLen - 8'(8'(convLen / 8'd12) * 8'd8));
    assign stepDone = (cycle_r == 8'd1);
    assign convDone = (state_r == SADC_COMPARE) && stepDone && (bitIdx_r == 4'd0);

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    // mode register, reserved bits forced to zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode_r <= `SADC_MODE_RESET;
        end else if (modeWr) begin
            mode_r <= regWdata & `SADC_MODE_MASK;
        end
    end

    // channel register, only the low two bits are stored
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            chan_r <= 2'(`SADC_CHAN_RESET);
        end else if (chanWr) begin
            chan_r <= regWdata[1:0];
        end
    end

    // ----------------------------------------
    // comparator input synchroniser
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            compSync1_r <= 1'b0;
            compSync2_r <= 1'b0;
        end else begin
            compSync1_r <= comparatorHigh;
            compSync2_r <= compSync1_r;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    // a mode write, or a channel write while enabled, restarts from sample, or stops when enable is cleared;
    // writes win over completion so no result is stored in that cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r <= SADC_IDLE;
            cycle_r <= 8'd0;
            bitIdx_r <= 4'd0;
            approx_r <= 8'h00;
            stepLen_r <= 8'd0;
        end else if (modeWr || chanWr) begin
            if (modeWr && !regWdata[`SADC_ENABLE_BIT]) begin
                state_r <= SADC_IDLE;
            end else if (modeWr || enable) begin
                state_r <= SADC_SAMPLE;
                cycle_r <= 8'd0;
            end
            approx_r <= 8'h00;
        end else begin
            unique case (state_r)
                SADC_IDLE: begin
                    cycle_r <= 8'd0;
                end
                SADC_SAMPLE: begin
                    if (cycle_r == 8'd0) begin
                        // length/12 per compare step, remainder to sampling
                        stepLen_r <= 8'(convLen / 8'd12);
                        // this cycle is the first sample cycle, so the whole span equals the length
                        cycle_r <= 8'(sampleLen - 8'd1);
                    end else if (stepDone) begin
                        state_r <= SADC_COMPARE;
                        bitIdx_r <= 4'd7;
                        approx_r <= 8'h80;
                        cycle_r <= stepLen_r;
                    end else begin
                        cycle_r <= 8'(cycle_r - 8'd1);
                    end
                end
                SADC_COMPARE: begin
                    if (stepDone) begin
                        // keep or drop the trial bit, then try the next one down
                        approx_r[bitIdx_r[2:0]] <= compSync2_r;
                        if (bitIdx_r != 4'd0) begin
                            approx_r[3'(bitIdx_r - 4'd1)] <= 1'b1;
                            bitIdx_r <= 4'(bitIdx_r - 4'd1);
                            cycle_r <= stepLen_r;
                        end else begin
                            state_r <= SADC_SAMPLE;
                            cycle_r <= 8'd0;
                        end
                    end else begin
                        cycle_r <= 8'(cycle_r - 8'd1);
                    end
                end
                default: state_r <= SADC_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // result, end pulse and first-result marker
    // ----------------------------------------
    // result has no reset: it is undefined until the first conversion ends
    always_ff @(posedge sys_clk) begin
        if (convDone && !modeWr && !chanWr) begin
            result_r <= {approx_r[7:1], compSync2_r};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            conversionEndIrq <= 1'b0;
        end else begin
            conversionEndIrq <= convDone && !modeWr && !chanWr;
        end
    end

    // flags the first result after enabling so software can drop it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            first_r <= 1'b0;
            firstResultFlag <= 1'b0;
        end else begin
            if (modeWr && regWdata[`SADC_ENABLE_BIT] && !enable) begin
                first_r <= 1'b1;
            end else if (convDone && !chanWr && !modeWr) begin
                first_r <= 1'b0;
                firstResultFlag <= first_r;
            end
        end
    end

    // ----------------------------------------
    // read port and analog drive
    // ----------------------------------------
    // read returns the old result in the completion cycle; the new one lands after
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            unique case (regAddr)
                `SADC_MODE_ADDR: regRdata <= mode_r;
                `SADC_CHAN_ADDR: regRdata <= {6'b0, chan_r};
                `SADC_RESULT_ADDR: regRdata <= result_r;
                default: regRdata <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            analogChannel <= 2'b00;
            sampleHold <= 1'b0;
            compareCode <= 8'h00;
        end else begin
            analogChannel <= chan_r;
            sampleHold <= (state_r == SADC_SAMPLE);
            compareCode <= approx_r;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_start_by_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ($past(state_r) == SADC_IDLE && state_r == SADC_SAMPLE) |-> $past(modeWr || chanWr))
        else $error("conversion started without a register write");
    chk_stop_no_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (modeWr && !regWdata[7]) |=> (state_r == SADC_IDLE && !conversionEndIrq))
        else $error("disable write did not stop conversion");
    chk_write_beats_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (convDone && (modeWr || chanWr)) |=> !conversionEndIrq)
        else $error("end pulse raised despite a register write");
    chk_end_one_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        conversionEndIrq |=> !conversionEndIrq)
        else $error("end pulse longer than one cycle");
    chk_restart_after_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (convDone && !modeWr && !chanWr) |=> state_r == SADC_SAMPLE)
        else $error("no immediate restart after completion");
    chk_result_loaded: assert property (@(posedge sys_clk) disable iff (!rst_n)
        conversionEndIrq |-> result_r == {$past(approx_r[7:1]), $past(compSync2_r)})
        else $error("result not copied from approximation");
    chk_msb_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ($past(state_r) == SADC_SAMPLE && state_r == SADC_COMPARE) |-> approx_r == 8'h80)
        else $error("approximation did not start at msb");
    chk_hold_during_cmp: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_r == SADC_COMPARE) |=> !sampleHold)
        else $error("sample commanded during compare");
    chk_channel_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (chanWr && enable && !modeWr) |=> state_r == SADC_SAMPLE)
        else $error("channel write did not restart conversion");
    cov_full_conv: cover property (@(posedge sys_clk) conversionEndIrq);
    cov_chan_abort: cover property (@(posedge sys_clk) chanWr && state_r == SADC_COMPARE);
    cov_read_at_end: cover property (@(posedge sys_clk) convDone && regRead);
endmodule // sadc_control

// File: rtl/sadc_consts.svh
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH
// ----------------------------------------
// register addresses and layouts
// ----------------------------------------
`define SADC_MODE_ADDR 16'hFF67
`define SADC_CHAN_ADDR 16'hFF68
`define SADC_RESULT_ADDR 16'hFF69
`define SADC_MODE_RESET 8'h00
`define SADC_CHAN_RESET 8'h00
`define SADC_ENABLE_BIT 7
`define SADC_TSEL_HI 5
`define SADC_TSEL_LO 3
`define SADC_MODE_MASK 8'hB8
`define SADC_CHAN_MASK 8'h03
// ----------------------------------------
// conversion timing, in main clock cycles
// ----------------------------------------
`define SADC_LEN_000 8'h90
`define SADC_LEN_001 8'h78
`define SADC_LEN_010 8'h60
`define SADC_LEN_100 8'h48
`define SADC_LEN_101 8'h3C
`define SADC_LEN_110 8'h30
`define SADC_STEPS 4'h8
`endif

// File: rtl/sadc_pkg.sv
package sadc_pkg;
    // ----------------------------------------
    // sequencer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        SADC_IDLE = 2'b00,
        SADC_SAMPLE = 2'b01,
        SADC_COMPARE = 2'b10
    } sadc_state_type;
endpackage

// File: bench/sadc_analog_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// analog macro: input levels, sample-hold and comparator
// ----------------------------------------
module sadc_analog_model #(
    parameter logic [7:0] LEVEL0 = 8'h3A,
    parameter logic [7:0] LEVEL1 = 8'hC5,
    parameter logic [7:0] LEVEL2 = 8'h01,
    parameter logic [7:0] LEVEL3 = 8'hFE
) (
    // clock
    input wire logic sys_clk,
    // control from the converter
    input wire logic [1:0] analogChannel,
    input wire logic sampleHold,
    input wire logic [7:0] compareCode,
    // decision back to the converter
    output logic comparatorHigh
);
    logic [7:0] heldLevel = 8'h00;
    // the capacitor follows the input only while sampling; a channel switch in hold goes unseen
    always @(posedge sys_clk) begin
        if (sampleHold) begin
            case (analogChannel)
                2'b00: heldLevel <= LEVEL0;
                2'b01: heldLevel <= LEVEL1;
                2'b10: heldLevel <= LEVEL2;
                default: heldLevel <= LEVEL3;
            endcase
        end
    end
    // comparator: high when the held input is at or above the trial tap
    assign comparatorHigh = (heldLevel >= compareCode);
endmodule // sadc_analog_model

// File: bench/tb_sadc_control.sv
`timescale 1ns/1ps
`include "sadc_consts.svh"
module tb_sadc_control
    import sadc_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] regRdata, compareCode, rd;
    logic [1:0] analogChannel;
    logic sampleHold, comparatorHigh, conversionEndIrq, firstResultFlag;
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;
    int irqCount = 0;
    int irqAt = 0;
    int t1, tw, n;
    int lens [6] = '{144, 120, 96, 72, 60, 48};
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    logic [7:0] levels [4] = '{8'h3A, 8'hC5, 8'h01, 8'hFE};
    // ----------------------------------------
    // clock, design and analog partner
    // ----------------------------------------
    always #5 sys_clk = ~sys_clk;
    sadc_control dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .analogChannel(analogChannel),
        .sampleHold(sampleHold), .compareCode(compareCode), .comparatorHigh(comparatorHigh),
        .conversionEndIrq(conversionEndIrq), .firstResultFlag(firstResultFlag));
    sadc_analog_model partner (.sys_clk(sys_clk), .analogChannel(analogChannel), .sampleHold(sampleHold),
        .compareCode(compareCode), .comparatorHigh(comparatorHigh));
    // irq monitor: the pulse stands one cycle, so it is counted at every edge
    always @(posedge sys_clk) begin
        cyc++;
        if (conversionEndIrq === 1'b1) begin
            irqCount++;
            irqAt = cyc;
        end
    end
    // ----------------------------------------
    // access tasks and comparison
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic regWr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1 regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(posedge sys_clk);
        #1 regWrite = 1'b0;
    endtask
    task automatic regRd(input logic [15:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1 regAddr = a;
        regRead = 1'b1;
        @(posedge sys_clk);
        #1 regRead = 1'b0;
        d = regRdata;
    endtask
    // waits for the next end pulse, bounded well above the longest conversion
    task automatic waitIrq();
        int target, k;
        target = irqCount + 1;
        k = 0;
        while (irqCount < target && k < 2000) begin
            @(posedge sys_clk);
            k++;
        end
        #1;
        if (irqCount < target) chk("irq arrival", 16'h0001, 16'h0000);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // watchdog: the tests need about 3100 cycles
    initial begin
        repeat (40000) @(posedge sys_clk);
        failures++;
        give_verdict();
    end
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        regRd(`SADC_MODE_ADDR, rd); chk("mode reset", 16'h0000, rd);
        regRd(`SADC_CHAN_ADDR, rd); chk("chan reset", 16'h0000, rd);
        regWr(`SADC_MODE_ADDR, 8'h47);
        regRd(`SADC_MODE_ADDR, rd); chk("mode fixed bits", 16'h0000, rd);
        regWr(`SADC_CHAN_ADDR, 8'h02);
        regRd(`SADC_CHAN_ADDR, rd); chk("chan readback", 16'h0002, rd);
        repeat (300) @(posedge sys_clk);
        chk("no start without enable", 16'h0000, irqCount[15:0]);
        $display("test registers done");
        // every legal time-select code: period between results, then the value stored
        // the model has no settling time, so the floor on conversion time is out of scope here
        regWr(`SADC_CHAN_ADDR, 8'h00);
        for (int i = 0; i < 6; i++) begin
            regWr(`SADC_MODE_ADDR, {2'b00, codes[i], 3'b000});
            regWr(`SADC_MODE_ADDR, {2'b10, codes[i], 3'b000});
            waitIrq();
            chk("first flag", 16'h0001, firstResultFlag);
            waitIrq();
            chk("later flag", 16'h0000, firstResultFlag);
            t1 = irqAt;
            waitIrq();
            n = irqAt - t1;
            chk("period", lens[i], n);
            regRd(`SADC_RESULT_ADDR, rd); chk("result ch0", levels[0], rd);
        end
        $display("test time select done");
        // every channel, software reads before each channel write
        for (int c = 0; c < 4; c++) begin
            regWr(`SADC_CHAN_ADDR, 8'(c));
            waitIrq();
            waitIrq();
            chk("analog channel", c, analogChannel);
            regRd(`SADC_RESULT_ADDR, rd); chk("result", levels[c], rd);
        end
        $display("test channels done");
        // channel write mid conversion restarts on the new channel
        regWr(`SADC_MODE_ADDR, 8'h20);
        regWr(`SADC_CHAN_ADDR, 8'h00);
        regWr(`SADC_MODE_ADDR, 8'hA0);
        waitIrq();
        repeat (20) @(posedge sys_clk);
        regWr(`SADC_CHAN_ADDR, 8'h01);
        tw = cyc;
        waitIrq();
        chk("restart span", 16'd73, 16'(irqAt - tw));
        regRd(`SADC_RESULT_ADDR, rd); chk("result after restart", levels[1], rd);
        $display("test restart done");
        // a read, then a channel write, each landing on the completion edge of one of two successive 72-cycle conversions
        regWr(`SADC_CHAN_ADDR, 8'h02);
        tw = cyc;
        repeat (tw + 70 - cyc) @(posedge sys_clk);
        regRd(`SADC_RESULT_ADDR, rd); chk("read at completion", levels[1], rd);
        regRd(`SADC_RESULT_ADDR, rd); chk("result after completion", levels[2], rd);
        n = irqCount;
        repeat (tw + 142 - cyc) @(posedge sys_clk);
        regWr(`SADC_CHAN_ADDR, 8'h01);
        waitIrq();
        chk("end pulses around write", 16'(n + 1), 16'(irqCount));
        chk("end after write", 16'd217, 16'(irqAt - tw));
        regRd(`SADC_RESULT_ADDR, rd); chk("result after write", levels[1], rd);
        $display("test completion conflicts done");
        // disabling mid conversion stores nothing
        repeat (20) @(posedge sys_clk);
        regWr(`SADC_MODE_ADDR, 8'h20);
        n = irqCount;
        repeat (300) @(posedge sys_clk);
        chk("no irq after stop", n, irqCount);
        chk("hold after stop", 16'h0000, sampleHold);
        regRd(`SADC_RESULT_ADDR, rd); chk("result kept", levels[1], rd);
        $display("test stop done");
        give_verdict();
    end
endmodule // tb_sadc_control
